// ---- pkg/itp_params.svh ----
// Purpose: offsets, field positions, reset values and levels for the interrupt/trap controller
// Assumes: 32-bit Avalon-MM word registers, byte addresses
// Notes: included by the controller, the assertion module and the bench; the package does not include it
`ifndef ITP_PARAMS_SVH
`define ITP_PARAMS_SVH
// register byte offsets
`define ITP_OFS_CTRL1 8'h00
`define ITP_OFS_FLAG 8'h04
`define ITP_OFS_ENABLE 8'h08
`define ITP_OFS_PRIO_LO 8'h0C
`define ITP_OFS_PRIO_HI 8'h10
`define ITP_OFS_CPU 8'h14
`define ITP_OFS_TIMED_IRQ_DISABLE 8'h18
`define ITP_OFS_STATUS 8'h1C
// control word field positions
`define ITP_BIT_NEST_DIS 15
`define ITP_BIT_ARITH 4
`define ITP_BIT_ADDR 3
`define ITP_BIT_STACK 2
`define ITP_BIT_CLKFAIL 1
// writable mask of the control word
`define ITP_CTRL1_MASK 16'h801E
// reset values
`define ITP_CTRL1_RST 16'h0000
`define ITP_PRIO_RST 3'h4
`define ITP_IPL_USER_MAX 4'h7
`define ITP_IPL_MASK_OR 8'h0E
// trap levels: clock fail, address, stack, arithmetic
`define ITP_LVL_CLKFAIL 4'hE
`define ITP_LVL_ADDR 4'hD
`define ITP_LVL_STACK 4'hC
`define ITP_LVL_ARITH 4'hB
`define ITP_TIMED_IRQ_DISABLE_LVL_MAX 3'h6
`endif

// ---- pkg/itp_pkg.sv ----
// Purpose: shared types for the interrupt/trap controller
// Assumes: itp_params.svh holds all numbers
// Notes: request and return carriers to and from the core
package itp_pkg;
    // request presented to the core
    typedef struct packed {
        logic       valid;  // a request is pending
        logic       trap;   // request is a trap
        logic [3:0] level;  // priority level 1..15
        logic [4:0] vector; // source index, or trap index for traps
    } itp_req_t;
    // what the core pushes/pops around a handler
    typedef struct packed {
        logic [15:0] pc;  // saved program counter
        logic [7:0]  slb; // saved status low byte
        logic [3:0]  ipl; // saved cpu priority level
    } itp_frame_t;
    // core sequencing state
    typedef enum logic [1:0] {ITP_IDLE, ITP_IN_HANDLER} itp_state_t;
endpackage

// ---- src/itp_arbiter.sv ----
// Purpose: pick the highest-priority enabled pending user source
// Assumes: priorities are 3-bit levels, 0 means source disabled
// Notes: lowest index wins a tie, natural-order tie break
`timescale 1ns/10ps
module itp_arbiter #(
    parameter int NSRC = 16
) (
    input wire logic [NSRC-1:0] pend,     // flag and enable per source
    input wire logic [NSRC*3-1:0] prio,   // packed 3-bit priority per source
    input wire logic [2:0] blk_max,       // levels at or below this are blocked by the timed disable
    output logic [2:0] best_lvl,          // winning level, 0 when none
    output logic [4:0] best_idx           // winning source index
);
    // linear scan; strict greater keeps the lowest index on ties
    always_comb begin
        best_lvl = 3'h0;
        best_idx = 5'h00;
        for (int i = 0; i < NSRC; i++) begin
            if (pend[i] && prio[i*3 +: 3] > blk_max && prio[i*3 +: 3] > best_lvl) begin
                best_lvl = prio[i*3 +: 3];
                best_idx = 5'(i);
            end
        end
    end
endmodule

// ---- src/itp_ctrl.sv ----
// Purpose: interrupt and trap controller with register file on Avalon-MM
// Assumes: single clock mclk, trap events are one-cycle pulses from same-domain logic
// Notes: core handshake is req/ack for entry and a return strobe for handler exit
//        saved frames live inside this block; a nest deeper than the frame stack is refused
`timescale 1ns/10ps
`include "itp_params.svh"
module itp_ctrl #(
    parameter int NSRC = 16
) (
    input wire logic mclk,                      // system clock 125 MHz
    input wire logic rst_b,                     // async reset, active low
    input wire logic [7:0] avs_address,         // byte address
    input wire logic avs_read,                  // read strobe
    input wire logic avs_write,                 // write strobe
    input wire logic [31:0] avs_writedata,      // write data
    input wire logic [3:0] avs_byteenable,      // byte lanes
    output logic [31:0] avs_readdata,           // read data
    output logic avs_waitrequest,               // stall
    input wire logic [NSRC-1:0] src_event,      // peripheral event pulses
    input wire logic [3:0] trap_event,          // arith, addr, stack, clkfail pulses in bits 3..0
    input wire logic insn_retire,               // one pulse per executed instruction
    output itp_pkg::itp_req_t irq_req,          // request to the core
    input wire logic irq_ack,                   // core takes the request
    input wire itp_pkg::itp_frame_t entry_frame, // pc pushed on entry; status and level come from slb_reg and ipl_reg
    input wire logic ret_strobe,                // return_from_irq executed
    output itp_pkg::itp_frame_t ret_frame,      // restored pc, status, level
    output logic ret_valid,                     // ret_frame valid pulse
    output logic [3:0] cpu_ipl                  // current cpu priority level
);
    import itp_pkg::*;

    // sixteen frames cover every level once over; a deeper nest is refused, never wrapped
    localparam int DEPTH = 16; // nesting depth of saved frames

    // register file and handler state
    logic [15:0] ctrl1_reg;          // interrupt_control_one
    logic [NSRC-1:0] flag_reg;       // source_flag_regs
    logic [NSRC-1:0] en_reg;         // source_enable_regs
    logic [NSRC*3-1:0] prio_reg;     // source_priority_regs
    logic [3:0] ipl_reg;             // cpu priority level
    logic [7:0] slb_reg;             // status low byte, ipl lives in bits 7:5 as in a core
    logic [15:0] timed_irq_disable_reg;           // timed disable remaining instructions
    itp_frame_t stack_mem [DEPTH];   // saved frames
    logic [4:0] sp_reg;              // frame stack pointer
    itp_state_t state_reg;           // handler state
    logic [31:0] rdata_reg;          // registered read data
    logic rd_done_reg;               // read answered this cycle

    // bus decode; a write is taken on the edge it is seen, so no wait state is needed
    // unmapped offsets select nothing: writes there are dropped and reads return zero
    wire wr_en = avs_write;
    wire sel_ctrl = avs_address == `ITP_OFS_CTRL1;
    wire sel_flag = avs_address == `ITP_OFS_FLAG;
    wire sel_en = avs_address == `ITP_OFS_ENABLE;
    wire sel_plo = avs_address == `ITP_OFS_PRIO_LO;
    wire sel_phi = avs_address == `ITP_OFS_PRIO_HI;
    wire sel_cpu = avs_address == `ITP_OFS_CPU;
    wire sel_timed_irq_disable = avs_address == `ITP_OFS_TIMED_IRQ_DISABLE;
    wire [15:0] wd16 = {avs_byteenable[1] ? avs_writedata[15:8] : 8'h00, avs_byteenable[0] ? avs_writedata[7:0] : 8'h00};
    wire [15:0] wm16 = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    // writes take one cycle, reads two (registered data)
    assign avs_waitrequest = avs_read && !rd_done_reg;
    assign avs_readdata = rdata_reg;

    // merge helper for byte-lane writes
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] d, input logic [15:0] m);
        merge16 = (old & ~m) | (d & m);
    endfunction

    // trap selection: highest trap level first
    wire [3:0] trap_pend = {ctrl1_reg[`ITP_BIT_ARITH], ctrl1_reg[`ITP_BIT_ADDR],
                            ctrl1_reg[`ITP_BIT_STACK], ctrl1_reg[`ITP_BIT_CLKFAIL]};
    wire [3:0] trap_lvl = trap_pend[0] ? `ITP_LVL_CLKFAIL : trap_pend[2] ? `ITP_LVL_ADDR :
                          trap_pend[1] ? `ITP_LVL_STACK : `ITP_LVL_ARITH;
    wire [4:0] trap_idx = trap_pend[0] ? 5'h01 : trap_pend[2] ? 5'h03 : trap_pend[1] ? 5'h02 : 5'h04;

    // user arbitration; enable gates the request, flag keeps it alive
    // the arbiter sees user sources only; traps are resolved above
    wire [NSRC-1:0] pend = flag_reg & en_reg;
    // the timed disable counts instructions, not clocks, so a stalled core stretches it
    wire [2:0] blk_max = (timed_irq_disable_reg != 16'h0000) ? `ITP_TIMED_IRQ_DISABLE_LVL_MAX : 3'h0;
    wire [2:0] best_lvl;
    wire [4:0] best_idx;
    itp_arbiter #(.NSRC(NSRC)) u_arb (
        .pend(pend),
        .prio(prio_reg),
        .blk_max(blk_max),
        .best_lvl(best_lvl),
        .best_idx(best_idx)
    );

    // nesting disabled: only idle core may take a user request; traps ignore this
    // a trap handler in progress also counts as busy for user sources
    wire nest_ok = !ctrl1_reg[`ITP_BIT_NEST_DIS] || state_reg == ITP_IDLE;
    wire user_ok = best_lvl != 3'h0 && {1'b0, best_lvl} > ipl_reg && nest_ok;
    wire trap_ok = |trap_pend && trap_lvl > ipl_reg;

    // request mux; traps beat user sources
    // a trap outranks every user level, so it is tested first
    always_comb begin
        irq_req = '0;
        if (trap_ok) begin
            irq_req = '{valid: 1'b1, trap: 1'b1, level: trap_lvl, vector: trap_idx};
        end else if (user_ok) begin
            irq_req = '{valid: 1'b1, trap: 1'b0, level: {1'b0, best_lvl}, vector: best_idx};
        end
    end
    // level is registered so the core never sees a glitch from a bus write
    assign cpu_ipl = ipl_reg;

    // entry handshake: the core's accept pulse only counts while a request stands
    wire take = irq_req.valid && irq_ack;
    // a full frame stack refuses entry; the request stays pending until a return frees a slot
    wire push = take && sp_reg != 5'(DEPTH);
    // a return with nothing saved is ignored rather than underflowing the pointer
    wire do_ret = ret_strobe && sp_reg != 5'h00;
    itp_frame_t top_frame; // frame a return would restore
    assign top_frame = stack_mem[4'(sp_reg - 5'h01)];

    // frame store: plain memory with no reset, so it stays out of the reset tree
    always_ff @(posedge mclk) begin
        if (push) begin
            stack_mem[sp_reg[3:0]] <= '{pc: entry_frame.pc, slb: slb_reg, ipl: ipl_reg};
        end
    end

    // control word: hardware set wins over software clear
    // only the nesting bit and the four trap flags are writable; the rest read as zero
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl1_reg <= `ITP_CTRL1_RST;
        end else begin
            ctrl1_reg <= ((wr_en && sel_ctrl) ? merge16(ctrl1_reg, wd16, wm16 & `ITP_CTRL1_MASK) : ctrl1_reg)
                         | {11'h000, trap_event, 1'b0};
        end
    end

    // source flags, enables, priorities
    // a write of zero clears a flag; an event in the same cycle still wins
    // priorities: the low word covers sources 0-7, the high word sources 8-15
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            flag_reg <= '0;
            en_reg <= '0;
            prio_reg <= {NSRC{`ITP_PRIO_RST}};
        end else begin
            flag_reg <= ((wr_en && sel_flag) ? merge16(flag_reg, wd16, wm16) : flag_reg) | src_event;
            if (wr_en && sel_en) en_reg <= merge16(en_reg, wd16, wm16);
            if (wr_en && sel_plo) prio_reg[23:0] <= avs_writedata[23:0];
            if (wr_en && sel_phi) prio_reg[47:24] <= avs_writedata[23:0];
        end
    end

    // cpu level, status byte, timed disable, handler entry and return
    // entry and return never both act in one cycle; entry wins
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            // the core starts at level 0, open to any enabled user source
            ipl_reg <= 4'h0;
            slb_reg <= 8'h00;
            timed_irq_disable_reg <= 16'h0000;
            sp_reg <= 5'h00;
            state_reg <= ITP_IDLE;
            ret_frame <= '0;
            ret_valid <= 1'b0;
        end else begin
            ret_valid <= 1'b0;
            if (timed_irq_disable_reg != 16'h0000 && insn_retire) timed_irq_disable_reg <= timed_irq_disable_reg - 16'h0001;
            // a fresh count written in the same cycle replaces the decrement
            if (wr_en && sel_timed_irq_disable) timed_irq_disable_reg <= avs_writedata[15:0];
            if (wr_en && sel_cpu) begin
                // status write; the level sits in bits 7:5 with bit 8 as its top bit
                // all three low level bits set give level 7, which blocks every user source
                slb_reg <= avs_writedata[7:0];
                ipl_reg <= {avs_writedata[8], avs_writedata[7:5]};
            end
            if (push) begin
                // entry: serve at the request's level; the old level is in the saved frame
                sp_reg <= sp_reg + 5'h01;
                ipl_reg <= irq_req.level;
                state_reg <= ITP_IN_HANDLER;
            end else if (do_ret) begin
                // return: pop the top frame and hand it back to the core
                ret_frame <= top_frame;
                ret_valid <= 1'b1;
                slb_reg <= top_frame.slb;
                ipl_reg <= top_frame.ipl;
                sp_reg <= sp_reg - 5'h01;
                if (sp_reg == 5'h01) state_reg <= ITP_IDLE;
            end
        end
    end

    // registered read path; every register is zero-extended into the word
    wire [31:0] rd_ctrl = {16'h0000, ctrl1_reg}; // control word
    wire [31:0] rd_flag = {16'h0000, flag_reg}; // source flags
    wire [31:0] rd_en = {16'h0000, en_reg}; // source enables
    wire [31:0] rd_plo = {8'h00, prio_reg[23:0]}; // priorities of sources 0-7
    wire [31:0] rd_phi = {8'h00, prio_reg[47:24]}; // priorities of sources 8-15
    wire [31:0] rd_cpu = {23'h0, ipl_reg[3], slb_reg}; // status byte plus level top bit
    wire [31:0] rd_timed_irq_disable = {16'h0000, timed_irq_disable_reg}; // remaining timed disable count
    wire [31:0] rd_stat = {26'h0, state_reg == ITP_IN_HANDLER, sp_reg}; // handler state and depth
    wire sel_stat = avs_address == `ITP_OFS_STATUS;
    wire [31:0] rmux = sel_ctrl ? rd_ctrl : sel_flag ? rd_flag : sel_en ? rd_en : sel_plo ? rd_plo :
                       sel_phi ? rd_phi : sel_cpu ? rd_cpu : sel_timed_irq_disable ? rd_timed_irq_disable : sel_stat ? rd_stat : 32'h0;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_reg <= 32'h0;
            rd_done_reg <= 1'b0;
        end else begin
            // second cycle of a read answers; the flag drops so a held read starts over
            rd_done_reg <= avs_read && !rd_done_reg;
            if (avs_read) rdata_reg <= rmux;
        end
    end
endmodule

// ---- bench/itp_ctrl_sva.sv ----
// Purpose: port assertions for the interrupt/trap controller
// Assumes: bench writes all byte lanes
// Notes: nesting bit and handler depth are shadowed from the bus and core pulses
`timescale 1ns/10ps
`include "itp_params.svh"
module itp_ctrl_sva #(
    parameter int NSRC = 16
) (
    input wire logic mclk, // clock
    input wire logic rst_b, // reset, active low
    input wire logic [7:0] avs_address, // byte address
    input wire logic avs_read, // read strobe
    input wire logic avs_write, // write strobe
    input wire logic [31:0] avs_writedata, // write data
    input wire logic avs_waitrequest, // stall
    input wire itp_pkg::itp_req_t irq_req, // request to core
    input wire logic irq_ack, // core accepts
    input wire logic ret_strobe, // return executed
    input wire logic [3:0] trap_event, // trap pulses
    input wire itp_pkg::itp_frame_t ret_frame, // restored frame
    input wire logic ret_valid, // restore pulse
    input wire logic [3:0] cpu_ipl // cpu level
);
    import itp_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    logic nest_reg; // shadow of nesting disable
    logic [4:0] depth_reg; // handlers open; drops on the return strobe, as the design leaves then
    // shadows follow bus writes and core pulses
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            nest_reg <= 1'b0;
            depth_reg <= 5'h00;
        end else begin
            if (avs_write && avs_address == `ITP_OFS_CTRL1) nest_reg <= avs_writedata[`ITP_BIT_NEST_DIS];
            depth_reg <= depth_reg + 5'(irq_ack && irq_req.valid) - 5'(ret_strobe);
        end
    end
    chk_above_cpu_lvl: assert property (irq_req.valid |-> irq_req.level > cpu_ipl)
        else $error("request not above cpu level");
    chk_user_lvl_max: assert property (irq_req.valid && !irq_req.trap |-> irq_req.level <= 4'h7)
        else $error("user request above level seven");
    chk_trap_lvl_range: assert property (irq_req.valid && irq_req.trap |-> irq_req.level inside {[4'hB:4'hE]})
        else $error("trap level out of range");
    chk_lvl7_blocks: assert property (cpu_ipl >= 4'h7 && irq_req.valid |-> irq_req.trap)
        else $error("user request at cpu level seven");
    chk_clkfail_trap: assert property (trap_event[0] && cpu_ipl < 4'hE && !irq_ack |=>
        irq_req.valid && irq_req.trap && irq_req.level == 4'hE)
        else $error("clock fail trap not requested");
    chk_entry_lvl: assert property (irq_ack && irq_req.valid |=> cpu_ipl == $past(irq_req.level))
        else $error("cpu level not raised on entry");
    chk_ret_restore: assert property (ret_valid |-> cpu_ipl == ret_frame.ipl)
        else $error("cpu level not restored on return");
    chk_nest_blocks: assert property (nest_reg && depth_reg != 5'h00 && irq_req.valid |-> irq_req.trap)
        else $error("user preempted with nesting disabled");
    chk_read_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("read wait not one cycle");
endmodule
bind itp_ctrl itp_ctrl_sva #(.NSRC(NSRC)) i_itp_ctrl_sva (.mclk(mclk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
    .irq_req(irq_req), .irq_ack(irq_ack), .ret_strobe(ret_strobe), .trap_event(trap_event), .ret_frame(ret_frame),
    .ret_valid(ret_valid), .cpu_ipl(cpu_ipl));

// ---- bench/itp_core_model.sv ----
// Purpose: core stand-in that accepts requests and returns from handlers
// Assumes: bench gates acceptance and orders returns
// Notes: pc moves every cycle so a stale frame never passes
`timescale 1ns/10ps
module itp_core_model (
    input wire logic mclk, // clock
    input wire logic rst_b, // reset, active low
    input wire itp_pkg::itp_req_t irq_req, // pending request
    input wire logic take, // bench allows acceptance
    input wire logic do_ret, // bench orders a return
    output logic irq_ack, // accept pulse
    output itp_pkg::itp_frame_t entry_frame, // pushed frame
    output logic ret_strobe // return pulse
);
    import itp_pkg::*;
    logic [15:0] pc_reg; // program counter stand-in
    // single-cycle pulses, never back to back
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            irq_ack <= 1'b0;
            ret_strobe <= 1'b0;
            pc_reg <= 16'h0000;
        end else begin
            irq_ack <= take && irq_req.valid && !irq_ack;
            ret_strobe <= do_ret && !ret_strobe;
            pc_reg <= pc_reg + 16'h0001;
        end
    end
    assign entry_frame = {pc_reg, 8'h00, 4'h0};
endmodule

// ---- bench/test_interrupt_trap_priority_control.sv ----
// Purpose: self-checking bench for the interrupt/trap controller
// Assumes: all byte lanes written
// Notes: seeded random levels with fixed corner cases
`timescale 1ns/10ps
`include "itp_params.svh"
module test_interrupt_trap_priority_control;
    import itp_pkg::*;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [15:0] src_event = 16'h0;
    logic [3:0] trap_event = 4'h0;
    logic insn_retire = 1'b0;
    logic take = 1'b0;
    logic do_ret = 1'b0;
    logic [31:0] avs_readdata, rd;
    logic avs_waitrequest, irq_ack, ret_strobe, ret_valid, en;
    itp_req_t irq_req;
    itp_frame_t entry_frame, ret_frame;
    logic [3:0] cpu_ipl;
    logic [15:0] pc_seen;
    int mismatches = 0;
    int cmp_count = 0;
    int s, p, q, c;
    itp_ctrl #(.NSRC(16)) i_itp_ctrl (.mclk(mclk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .src_event(src_event), .trap_event(trap_event), .insn_retire(insn_retire),
        .irq_req(irq_req), .irq_ack(irq_ack), .entry_frame(entry_frame), .ret_strobe(ret_strobe),
        .ret_frame(ret_frame), .ret_valid(ret_valid), .cpu_ipl(cpu_ipl));
    itp_core_model i_itp_core_model (.mclk(mclk), .rst_b(rst_b), .irq_req(irq_req), .take(take), .do_ret(do_ret),
        .irq_ack(irq_ack), .entry_frame(entry_frame), .ret_strobe(ret_strobe));
    initial begin
        forever #4 mclk = ~mclk;
    end
    function automatic logic [31:0] req_now();
        return 32'({irq_req.valid, irq_req.valid ? {irq_req.level, irq_req.vector} : 9'h000});
    endfunction
    function automatic logic [31:0] exp_req(input logic v, input int lvl, input int idx);
        return v ? 32'({1'b1, 4'(lvl), 5'(idx)}) : 32'h0;
    endfunction
    // trap i is clock fail, stack, address, arithmetic for i = 0..3; its vector is i + 1
    function automatic logic [31:0] exp_trap(input int i);
        logic [3:0] lvl;
        lvl = (i == 3) ? `ITP_LVL_ARITH : (i == 2) ? `ITP_LVL_ADDR : (i == 1) ? `ITP_LVL_STACK : `ITP_LVL_CLKFAIL;
        return 32'({1'b1, lvl, 5'(i + 1)});
    endfunction
    task finish_test;
        if (mismatches == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // bounded wait: sel picks restore pulse, else accept pulse
    task wait_hi(input logic sel);
        int n;
        n = 0;
        while ((sel ? ret_valid : irq_ack) !== 1'b1) begin
            n++;
            if (n > 50) begin
                mismatches++;
                finish_test();
            end
            @(posedge mclk);
        end
    endtask
    // one bus cycle, held until waitrequest is seen low, then an idle edge
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0) begin
            n++;
            if (n > 20) begin
                mismatches++;
                finish_test();
            end
            @(posedge mclk);
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge mclk);
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        cmp(rd, exp);
    endtask
    task pulse_src(input logic [15:0] m);
        src_event <= m;
        @(posedge mclk);
        src_event <= 16'h0;
        @(posedge mclk);
    endtask
    initial begin
        s = $urandom(10889);
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        rchk(`ITP_OFS_CTRL1, 32'h0);
        rchk(`ITP_OFS_PRIO_LO, 32'h924924);
        rchk(`ITP_OFS_PRIO_HI, 32'h924924);
        rchk(8'h24, 32'h0);
        s = $urandom;
        bus(1'b1, `ITP_OFS_CTRL1, 32'(s));
        rchk(`ITP_OFS_CTRL1, 32'(s) & 32'h801E);
        bus(1'b1, `ITP_OFS_CTRL1, 32'h0);
        // each trap pulse: level, sticky flag, software clear
        for (int i = 0; i < 4; i++) begin
            trap_event[i] <= 1'b1;
            @(posedge mclk);
            trap_event <= 4'h0;
            @(posedge mclk);
            cmp(32'({irq_req.trap, irq_req.level, irq_req.vector}), exp_trap(i));
            repeat (3) @(posedge mclk);
            rchk(`ITP_OFS_CTRL1, 32'h1 << (i + 1));
            bus(1'b1, `ITP_OFS_CTRL1, 32'h0);
            rchk(`ITP_OFS_CTRL1, 32'h0);
        end
        // user source against cpu level, enable and timed disable
        for (int k = 0; k < 12; k++) begin
            s = $urandom_range(7, 0);
            p = (k == 0) ? 7 : $urandom_range(7, 1);
            q = (k == 0) ? 6 : $urandom_range(7, 0);
            c = (k % 3) * 2;
            en = (k % 4 != 1);
            bus(1'b1, `ITP_OFS_PRIO_LO, 32'({8{3'(p)}}));
            bus(1'b1, `ITP_OFS_FLAG, 32'h0);
            bus(1'b1, `ITP_OFS_ENABLE, 32'(en) << s);
            bus(1'b1, `ITP_OFS_CPU, 32'(q) << 5);
            bus(1'b1, `ITP_OFS_TIMED_IRQ_DISABLE, 32'(c));
            pulse_src(16'h1 << s);
            cmp(req_now(), exp_req(en && p > q && (c == 0 || p == 7), p, s));
            if (c != 0) begin
                insn_retire <= 1'b1;
                repeat (c) @(posedge mclk);
                insn_retire <= 1'b0;
                @(posedge mclk);
            end
            cmp(req_now(), exp_req(en && p > q, p, s));
        end
        bus(1'b1, `ITP_OFS_CPU, 32'h0);
        bus(1'b1, `ITP_OFS_PRIO_LO, 32'h3D);
        bus(1'b1, `ITP_OFS_FLAG, 32'h0);
        bus(1'b1, `ITP_OFS_ENABLE, 32'h3);
        pulse_src(16'h1);
        take <= 1'b1;
        wait_hi(1'b0);
        pc_seen = entry_frame.pc;
        take <= 1'b0;
        rchk(`ITP_OFS_STATUS, 32'h21);
        bus(1'b1, `ITP_OFS_CTRL1, 32'h8000);
        pulse_src(16'h2);
        cmp(req_now(), 32'h0);
        trap_event <= 4'h8;
        @(posedge mclk);
        trap_event <= 4'h0;
        @(posedge mclk);
        cmp(req_now(), exp_req(1'b1, 11, 4));
        bus(1'b1, `ITP_OFS_CTRL1, 32'h0);
        cmp(req_now(), exp_req(1'b1, 7, 1));
        bus(1'b1, `ITP_OFS_FLAG, 32'h1);
        do_ret <= 1'b1;
        @(posedge mclk);
        do_ret <= 1'b0;
        wait_hi(1'b1);
        cmp(32'(ret_frame.pc), 32'(pc_seen));
        cmp(32'(cpu_ipl), 32'h0);
        take <= 1'b1;
        wait_hi(1'b0);
        take <= 1'b0;
        @(posedge mclk);
        cmp(32'(cpu_ipl), 32'h5);
        finish_test();
    end
endmodule
